// >>> hdfc_top.sv
// What this block does
// - The status register shows the tag of the next receive byte, 00 body, 01 first, 10 last of a good packet.
// - Tag 11 means the next receive byte is the last byte of a packet received in error.
// - The transmit fill code reads 00 at status level, 01 at threshold, 10 empty, 11 below threshold.
// - The receive fill code reads 00 empty, 01 below threshold, 10 at status level, 11 at threshold.
// - Interrupt bit 2 follows transmit underrun when the select bit is one, else receive frame abort.
// - With the cycle bit set the transmit byte counter cycles through its loaded count repeatedly.
// - With the CRC-inhibit bit set no frame check sequence follows a byte tagged as end of packet.
// - The host may tag the next transmit byte as end of packet, the tag clears after that write.
// - With the short-address bit set the receiver matches seven address bits with bit 0 of the byte at one.
// - Receive FIFO reset marks the FIFO empty and holds the receiver off until the next flag, data kept.
// - Transmit FIFO reset marks the FIFO empty, data kept, and the bit clears on the next FIFO write.
`timescale 1ns/1ps
`include "hdfc_defines.svh"

module hdfc_top #(
   parameter int unsigned DEPTH           = `HDFC_FIFO_DEPTH,
   parameter int unsigned TX_STATUS_LEVEL = `HDFC_STATUS_LEVEL,
   parameter int unsigned TX_INT_LEVEL    = `HDFC_INT_LEVEL,
   parameter int unsigned RX_STATUS_LEVEL = `HDFC_STATUS_LEVEL,
   parameter int unsigned RX_INT_LEVEL    = `HDFC_INT_LEVEL
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Host register port
   input  wire logic       cs_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o,
   // Transmitter side
   input  wire logic       tx_pull_i,
   output logic            tx_valid_o,
   output logic      [7:0] tx_byte_o,
   output logic            tx_end_o,
   output logic            tx_abandon_o,
   output logic            tx_fcs_append_o,
   output logic            tx_underrun_o,
   output logic            tx_count_cycle_o,
   // Receiver side
   input  wire logic       rx_push_i,
   input  wire logic [7:0] rx_byte_i,
   input  wire logic [1:0] rx_tag_i,
   input  wire logic       rx_flag_i,
   input  wire logic       rx_abort_i,
   output logic            rx_enable_o,
   output logic            rx_short_addr_o,
   // Interrupt register bit 2 source
   output logic            int_bit2_evt_o
);

   localparam int unsigned AW = $clog2(DEPTH);

   hdfc_pkg::hdfc_top_s s;
   hdfc_pkg::hdfc_top_s next_s;
   logic                rst_n;

   // Bus decode
   logic       host_wr;
   logic       host_rd;
   logic       wr_tx_fifo;
   logic       wr_ctrl_first;
   logic       wr_ctrl_second;
   logic       rd_rx_fifo;

   // Transmit FIFO
   logic [9:0] tx_head;
   logic [AW:0] tx_count;
   logic       tx_empty;
   logic       tx_full;
   logic       tx_push;
   logic       tx_pop;
   logic       tx_flush;
   logic [1:0] tx_fill;

   // Receive FIFO
   logic [9:0] rx_head;
   logic [AW:0] rx_count;
   logic       rx_empty;
   logic       rx_full;
   logic       rx_push;
   logic       rx_pop;
   logic       rx_flush;
   logic [1:0] rx_fill;
   logic [1:0] rx_next_tag;
   logic [7:0] status_word;

   // Reset released through two flops kept in the state struct
   assign rst_n = s.rst_sync;

   assign host_wr        = cs_i && wr_i;
   assign host_rd        = cs_i && rd_i && !wr_i;
   assign wr_tx_fifo     = host_wr && (addr_i == `HDFC_ADDR_TX_FIFO);
   assign wr_ctrl_first  = host_wr && (addr_i == `HDFC_ADDR_CTRL_FIRST);
   assign wr_ctrl_second = host_wr && (addr_i == `HDFC_ADDR_CTRL_SECOND);
   assign rd_rx_fifo     = host_rd && (addr_i == `HDFC_ADDR_RX_FIFO);

   // Writes to a full FIFO are dropped inside the FIFO
   assign tx_push  = wr_tx_fifo;
   assign tx_pop   = tx_pull_i;
   assign tx_flush = wr_ctrl_second && wdata_i[`HDFC_C2_TX_FIFO_RESET];

   // Receiver drops bytes while held off after a FIFO reset
   assign rx_push  = rx_push_i && !s.rx_hold;
   assign rx_pop   = rd_rx_fifo;
   assign rx_flush = wr_ctrl_second && wdata_i[`HDFC_C2_RX_FIFO_RESET];

   hdfc_fifo #(
      .WIDTH (10),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_tx_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n),
      .push_i      (tx_push),
      .push_data_i ({s.packet_end_tag, s.frame_abandon, wdata_i}),
      .pop_i       (tx_pop),
      .flush_i     (tx_flush),
      .head_o      (tx_head),
      .count_o     (tx_count),
      .empty_o     (tx_empty),
      .full_o      (tx_full)
   );

   hdfc_fifo #(
      .WIDTH (10),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_rx_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n),
      .push_i      (rx_push),
      .push_data_i ({rx_tag_i, rx_byte_i}),
      .pop_i       (rx_pop),
      .flush_i     (rx_flush),
      .head_o      (rx_head),
      .count_o     (rx_count),
      .empty_o     (rx_empty),
      .full_o      (rx_full)
   );

   hdfc_fill #(
      .CW           (AW + 1),
      .STATUS_LEVEL (TX_STATUS_LEVEL),
      .INT_LEVEL    (TX_INT_LEVEL),
      .IS_TX        (1'b1)
   ) u_tx_fill (
      .count_i (tx_count),
      .empty_i (tx_empty),
      .code_o  (tx_fill)
   );

   hdfc_fill #(
      .CW           (AW + 1),
      .STATUS_LEVEL (RX_STATUS_LEVEL),
      .INT_LEVEL    (RX_INT_LEVEL),
      .IS_TX        (1'b0)
   ) u_rx_fill (
      .count_i (rx_count),
      .empty_i (rx_empty),
      .code_o  (rx_fill)
   );

   // Empty FIFO has no next byte, so its tag reads as body
   assign rx_next_tag = rx_empty ? `HDFC_TAG_BODY : rx_head[9:8];

   // Built purely from live state; reading it changes nothing
   always_comb begin
      status_word = `HDFC_READ_NONE;
      status_word[`HDFC_ST_RX_TAG_HI:`HDFC_ST_RX_TAG_LO]   = rx_next_tag;
      status_word[`HDFC_ST_TX_FILL_HI:`HDFC_ST_TX_FILL_LO] = tx_fill;
      status_word[`HDFC_ST_RX_FILL_HI:`HDFC_ST_RX_FILL_LO] = rx_fill;
   end

   always_comb begin
      next_s          = s;
      next_s.tx_valid = 1'b0;
      next_s.tx_underrun = 1'b0;

      // Read data, registered; unmapped addresses read zero
      if (host_rd) begin
         unique case (addr_i)
            `HDFC_ADDR_STATUS: begin
               next_s.rdata = status_word;
            end
            `HDFC_ADDR_CTRL_SECOND: begin
               next_s.rdata = s.ctrl_second;
            end
            `HDFC_ADDR_CTRL_FIRST: begin
               next_s.rdata = `HDFC_READ_NONE;
               next_s.rdata[`HDFC_C1_PACKET_END]    = s.packet_end_tag;
               next_s.rdata[`HDFC_C1_FRAME_ABANDON] = s.frame_abandon;
            end
            `HDFC_ADDR_RX_FIFO: begin
               next_s.rdata = rx_empty ? `HDFC_READ_NONE : rx_head[7:0];
            end
            default: begin
               next_s.rdata = `HDFC_READ_NONE;
            end
         endcase
      end

      // Tags apply to the next byte and clear after it is written
      if (wr_ctrl_first) begin
         next_s.packet_end_tag = wdata_i[`HDFC_C1_PACKET_END];
         next_s.frame_abandon  = wdata_i[`HDFC_C1_FRAME_ABANDON];
      end else if (wr_tx_fifo) begin
         next_s.packet_end_tag = 1'b0;
         next_s.frame_abandon  = 1'b0;
      end

      // Reserved bits are stored as written; host keeps them zero
      if (wr_ctrl_second) begin
         next_s.ctrl_second = wdata_i;
      end else if (wr_tx_fifo) begin
         next_s.ctrl_second[`HDFC_C2_TX_FIFO_RESET] = 1'b0;
      end

      // Set by the reset write wins over a flag in the same cycle
      if (rx_flush) begin
         next_s.rx_hold = 1'b1;
      end else if (rx_flag_i) begin
         next_s.rx_hold = 1'b0;
      end

      // Byte handed to the transmitter on its pull
      if (tx_pull_i) begin
         if (!tx_empty) begin
            next_s.tx_valid   = 1'b1;
            next_s.tx_byte    = tx_head[7:0];
            next_s.tx_end     = tx_head[9];
            next_s.tx_abandon = tx_head[8];
            next_s.tx_fcs     = tx_head[9] && !s.ctrl_second[`HDFC_C2_CRC_INHIBIT];
         end else begin
            next_s.tx_underrun = 1'b1;
         end
      end

      // Shared interrupt bit 2 source
      next_s.bit2_evt = s.ctrl_second[`HDFC_C2_INTSEL] ?
                        (tx_pull_i && tx_empty) : rx_abort_i;

      // Other state held at reset until the release has passed both flops
      if (!s.rst_sync) begin
         next_s = '0;
      end
      next_s.rst_meta = 1'b1;
      next_s.rst_sync = s.rst_meta;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s.rst_meta       <= 1'b0;
         s.rst_sync       <= 1'b0;
         s.ctrl_second    <= `HDFC_C2_RESET;
         s.packet_end_tag <= 1'b0;
         s.frame_abandon  <= 1'b0;
         s.rx_hold        <= 1'b0;
         s.rdata          <= `HDFC_READ_NONE;
         s.tx_byte        <= `HDFC_READ_NONE;
         s.tx_end         <= 1'b0;
         s.tx_abandon     <= 1'b0;
         s.tx_fcs         <= 1'b0;
         s.tx_valid       <= 1'b0;
         s.tx_underrun    <= 1'b0;
         s.bit2_evt       <= 1'b0;
      end else begin
         s.ctrl_second    <= next_s.ctrl_second;
         s.packet_end_tag <= next_s.packet_end_tag;
         s.frame_abandon  <= next_s.frame_abandon;
         s.rx_hold        <= next_s.rx_hold;
         s.rdata          <= next_s.rdata;
         s.tx_byte        <= next_s.tx_byte;
         s.tx_end         <= next_s.tx_end;
         s.tx_abandon     <= next_s.tx_abandon;
         s.tx_fcs         <= next_s.tx_fcs;
         s.tx_valid       <= next_s.tx_valid;
         s.tx_underrun    <= next_s.tx_underrun;
         s.bit2_evt       <= next_s.bit2_evt;
         s.rst_meta       <= next_s.rst_meta;
         s.rst_sync       <= next_s.rst_sync;
      end
   end

   assign rdata_o          = s.rdata;
   assign tx_valid_o       = s.tx_valid;
   assign tx_byte_o        = s.tx_byte;
   assign tx_end_o         = s.tx_end;
   assign tx_abandon_o     = s.tx_abandon;
   assign tx_fcs_append_o  = s.tx_fcs;
   assign tx_underrun_o    = s.tx_underrun;
   // Byte counter itself lives in the transmitter
   assign tx_count_cycle_o = s.ctrl_second[`HDFC_C2_CYCLE];
   assign rx_enable_o      = !s.rx_hold;
   // Address matcher lives in the receiver; it sees bit 0 rule when set
   assign rx_short_addr_o  = s.ctrl_second[`HDFC_C2_SHORT_ADDR];
   assign int_bit2_evt_o   = s.bit2_evt;

endmodule // hdfc_top

// >>> hdfc_defines.svh
`ifndef HDFC_DEFINES_SVH
`define HDFC_DEFINES_SVH

// Register addresses
`define HDFC_ADDR_TX_FIFO       8'h10
`define HDFC_ADDR_RX_FIFO       8'h11
`define HDFC_ADDR_CTRL_FIRST    8'h13
`define HDFC_ADDR_STATUS        8'h14
`define HDFC_ADDR_CTRL_SECOND   8'h15

// First control register tag bits
`define HDFC_C1_PACKET_END      4
`define HDFC_C1_FRAME_ABANDON   3

// Second control register bits
`define HDFC_C2_INTSEL          7
`define HDFC_C2_CYCLE           6
`define HDFC_C2_CRC_INHIBIT     5
`define HDFC_C2_SHORT_ADDR      4
`define HDFC_C2_RSV_HI          3
`define HDFC_C2_RSV_LO          2
`define HDFC_C2_RX_FIFO_RESET   1
`define HDFC_C2_TX_FIFO_RESET   0
`define HDFC_C2_RESET           8'h00

// Status register fields
`define HDFC_ST_RX_TAG_HI       5
`define HDFC_ST_RX_TAG_LO       4
`define HDFC_ST_TX_FILL_HI      3
`define HDFC_ST_TX_FILL_LO      2
`define HDFC_ST_RX_FILL_HI      1
`define HDFC_ST_RX_FILL_LO      0

// Receive byte tags
`define HDFC_TAG_BODY           2'h0
`define HDFC_TAG_FIRST          2'h1
`define HDFC_TAG_GOOD_LAST      2'h2
`define HDFC_TAG_BAD_LAST       2'h3

// Transmit fill codes
`define HDFC_TX_AT_STATUS       2'h0
`define HDFC_TX_AT_THRESH       2'h1
`define HDFC_TX_EMPTY           2'h2
`define HDFC_TX_BELOW_THRESH    2'h3

// Receive fill codes
`define HDFC_RX_EMPTY           2'h0
`define HDFC_RX_BELOW_THRESH    2'h1
`define HDFC_RX_AT_STATUS       2'h2
`define HDFC_RX_AT_THRESH       2'h3

// Sizes and default levels
`define HDFC_FIFO_DEPTH         128
`define HDFC_STATUS_LEVEL       96
`define HDFC_INT_LEVEL          32
`define HDFC_READ_NONE          8'h00

`endif

// >>> hdfc_pkg.sv
package hdfc_pkg;

   typedef struct packed {
      logic       rst_meta;
      logic       rst_sync;
      logic [7:0] ctrl_second;
      logic       packet_end_tag;
      logic       frame_abandon;
      logic       rx_hold;
      logic [7:0] rdata;
      logic [7:0] tx_byte;
      logic       tx_end;
      logic       tx_abandon;
      logic       tx_fcs;
      logic       tx_valid;
      logic       tx_underrun;
      logic       bit2_evt;
   } hdfc_top_s;

endpackage

// >>> hdfc_fifo.sv
`timescale 1ns/1ps
`include "hdfc_defines.svh"

module hdfc_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = `HDFC_FIFO_DEPTH,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Fill side
   input  wire logic             push_i,
   input  wire logic [WIDTH-1:0] push_data_i,
   // Drain side
   input  wire logic             pop_i,
   input  wire logic             flush_i,
   output logic      [WIDTH-1:0] head_o,
   // Fill state
   output logic      [AW:0]      count_o,
   output logic                  empty_o,
   output logic                  full_o
);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } hdfc_ptr_s;

   hdfc_ptr_s        s;
   hdfc_ptr_s        next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             do_push;
   logic             do_pop;

   assign empty_o = (s.cnt == '0);
   assign full_o  = (s.cnt == (AW+1)'(DEPTH));
   assign count_o = s.cnt;
   assign head_o  = mem[s.rd];
   // Flush moves pointers only; stored bytes stay as they were
   assign do_push = push_i && !full_o && !flush_i;
   assign do_pop  = pop_i && !empty_o && !flush_i;

   always_comb begin
      next_s = s;
      if (flush_i) begin
         next_s.rd  = s.wr;
         next_s.cnt = '0;
      end else begin
         if (do_push) begin
            next_s.wr = (s.wr == AW'(DEPTH-1)) ? '0 : s.wr + 1'b1;
         end
         if (do_pop) begin
            next_s.rd = (s.rd == AW'(DEPTH-1)) ? '0 : s.rd + 1'b1;
         end
         next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem[s.wr] <= push_data_i;
      end
   end

endmodule // hdfc_fifo

// >>> hdfc_fill.sv
`timescale 1ns/1ps
`include "hdfc_defines.svh"

module hdfc_fill #(
   parameter int unsigned CW           = 8,
   parameter int unsigned STATUS_LEVEL = `HDFC_STATUS_LEVEL,
   parameter int unsigned INT_LEVEL    = `HDFC_INT_LEVEL,
   parameter bit          IS_TX        = 1'b1
) (
   // Fill state in
   input  wire logic [CW-1:0] count_i,
   input  wire logic          empty_i,
   // Two-bit fill code out
   output logic      [1:0]    code_o
);

   logic at_status;
   logic at_thresh;

   assign at_status = (count_i >= CW'(STATUS_LEVEL));
   assign at_thresh = (count_i >= CW'(INT_LEVEL));

   // Empty checked first so a zero threshold still reads empty
   always_comb begin
      if (IS_TX) begin
         if (empty_i) begin
            code_o = `HDFC_TX_EMPTY;
         end else if (at_status) begin
            code_o = `HDFC_TX_AT_STATUS;
         end else if (at_thresh) begin
            code_o = `HDFC_TX_AT_THRESH;
         end else begin
            code_o = `HDFC_TX_BELOW_THRESH;
         end
      end else begin
         if (empty_i) begin
            code_o = `HDFC_RX_EMPTY;
         end else if (at_status) begin
            code_o = `HDFC_RX_AT_STATUS;
         end else if (at_thresh) begin
            code_o = `HDFC_RX_AT_THRESH;
         end else begin
            code_o = `HDFC_RX_BELOW_THRESH;
         end
      end
   end

endmodule // hdfc_fill

// >>> hdfc_chk.sv
`timescale 1ns/1ps
`include "hdfc_defines.svh"

module hdfc_chk (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   // Host port
   input wire logic       cs_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   // Line side
   input wire logic       tx_pull_i,
   input wire logic       tx_valid_o,
   input wire logic       tx_end_o,
   input wire logic       tx_fcs_append_o,
   input wire logic       tx_underrun_o,
   input wire logic       tx_count_cycle_o,
   input wire logic       rx_flag_i,
   input wire logic       rx_abort_i,
   input wire logic       rx_enable_o,
   input wire logic       rx_short_addr_o,
   input wire logic       int_bit2_evt_o
);
   logic isel;
   logic crci;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_c2_wr;
      cs_i && wr_i && addr_i == `HDFC_ADDR_CTRL_SECOND;
   endsequence
   sequence s_st_rd;
      cs_i && rd_i && !wr_i && addr_i == `HDFC_ADDR_STATUS;
   endsequence

   // Mirror of the interrupt-select and CRC-inhibit bits that outputs depend on
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         isel <= 1'b0;
         crci <= 1'b0;
      end else if (cs_i && wr_i && addr_i == `HDFC_ADDR_CTRL_SECOND) begin
         isel <= wdata_i[7];
         crci <= wdata_i[5];
      end
   end

   fcs_after_end_a: assert property (tx_valid_o && tx_end_o |-> tx_fcs_append_o == !crci)
      else $error("fcs flag wrong on end byte");
   fcs_only_end_a: assert property (tx_valid_o && !tx_end_o |-> !tx_fcs_append_o)
      else $error("fcs flag on body byte");
   pull_answer_a: assert property (tx_pull_i |=> tx_valid_o ^ tx_underrun_o)
      else $error("pull not answered");
   abort_evt_a: assert property (!isel && rx_abort_i |=> int_bit2_evt_o)
      else $error("abort event missing");
   under_evt_a: assert property (isel && tx_underrun_o |-> ##[0:1] int_bit2_evt_o)
      else $error("underrun event missing");
   evt_cause_a: assert property (int_bit2_evt_o |->
      (isel ? (tx_underrun_o || $past(tx_underrun_o)) : $past(rx_abort_i)))
      else $error("bit2 event without cause");
   cycle_bit_a: assert property (s_c2_wr |=> tx_count_cycle_o == $past(wdata_i[6]))
      else $error("cycle bit not applied");
   short_addr_a: assert property (s_c2_wr |=> rx_short_addr_o == $past(wdata_i[4]))
      else $error("short address bit not applied");
   rx_hold_a: assert property (s_c2_wr ##0 wdata_i[1] |=> !rx_enable_o)
      else $error("receiver not held");
   rx_wake_a: assert property ($rose(rx_enable_o) |-> $past(rx_flag_i))
      else $error("receiver woke without flag");
   rdata_hold_a: assert property (!(cs_i && rd_i) |=> $stable(rdata_o))
      else $error("read data changed without read");
   status_top_a: assert property (s_st_rd |=> rdata_o[7:6] == 2'h0)
      else $error("status top bits set");
endmodule // hdfc_chk

bind hdfc_top hdfc_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_i(cs_i), .wr_i(wr_i), .rd_i(rd_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .tx_pull_i(tx_pull_i), .tx_valid_o(tx_valid_o),
   .tx_end_o(tx_end_o), .tx_fcs_append_o(tx_fcs_append_o), .tx_underrun_o(tx_underrun_o),
   .tx_count_cycle_o(tx_count_cycle_o), .rx_flag_i(rx_flag_i), .rx_abort_i(rx_abort_i),
   .rx_enable_o(rx_enable_o), .rx_short_addr_o(rx_short_addr_o), .int_bit2_evt_o(int_bit2_evt_o));

// >>> hdfc_line_model.sv
`timescale 1ns/1ps

module hdfc_line_model (
   // Clock
   input  wire logic       clk_i,
   // Transmit link
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic       tx_end_i,
   input  wire logic       tx_abandon_i,
   input  wire logic       tx_fcs_i,
   input  wire logic       tx_underrun_i,
   output logic            tx_pull_o,
   // Receive link
   output logic            rx_push_o,
   output logic      [7:0] rx_byte_o,
   output logic      [1:0] rx_tag_o,
   output logic            rx_flag_o,
   output logic            rx_abort_o
);
   initial begin
      tx_pull_o = 1'b0;
      rx_push_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_tag_o = 2'h0;
      rx_flag_o = 1'b0;
      rx_abort_o = 1'b0;
   end

   // Gap mimics a slow transmitter
   task automatic pull(input int gap, output logic [11:0] res);
      repeat (gap + 1) @(posedge clk_i);
      tx_pull_o <= 1'b1;
      @(posedge clk_i);
      tx_pull_o <= 1'b0;
      #1;
      res = {tx_valid_i, tx_underrun_i, tx_abandon_i, tx_end_i, tx_byte_i};
   endtask

   // Idle lines show the inverse so stale data never looks valid
   task automatic push(input logic [7:0] b, input logic [1:0] t);
      @(posedge clk_i);
      rx_push_o <= 1'b1;
      rx_byte_o <= b;
      rx_tag_o <= t;
      @(posedge clk_i);
      rx_push_o <= 1'b0;
      rx_byte_o <= ~b;
      rx_tag_o <= ~t;
   endtask

   task automatic pulse(input logic is_abort);
      @(posedge clk_i);
      rx_flag_o <= !is_abort;
      rx_abort_o <= is_abort;
      @(posedge clk_i);
      rx_flag_o <= 1'b0;
      rx_abort_o <= 1'b0;
   endtask
endmodule // hdfc_line_model

// >>> hdlc_fifo_status_and_control_tb.sv
`timescale 1ns/1ps
`include "hdfc_defines.svh"

module hdlc_fifo_status_and_control_tb;
   localparam int unsigned DEPTH = 8;
   localparam int unsigned LV_ST = 6;
   localparam int unsigned LV_IN = 2;
   localparam logic [7:0] A_C2 = `HDFC_ADDR_CTRL_SECOND;
   logic clk_i = 1'b0;
   logic rst_n = 1'b0;
   logic cs = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, tb, rb;
   logic tv, te, ta, tf, tu, tcyc, rp, rf, ra, ren, rsh, evt, tp;
   logic [1:0] rt;
   logic [9:0] txq[$];
   logic [9:0] rxq[$];
   logic [7:0] v, d;
   logic [11:0] r;
   logic crci;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;

   always #25 clk_i = ~clk_i;

   hdfc_top #(.DEPTH(DEPTH), .TX_STATUS_LEVEL(LV_ST), .TX_INT_LEVEL(LV_IN), .RX_STATUS_LEVEL(LV_ST),
      .RX_INT_LEVEL(LV_IN)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n), .cs_i(cs), .wr_i(wr), .rd_i(rd),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .tx_pull_i(tp), .tx_valid_o(tv), .tx_byte_o(tb),
      .tx_end_o(te), .tx_abandon_o(ta), .tx_fcs_append_o(tf), .tx_underrun_o(tu), .tx_count_cycle_o(tcyc),
      .rx_push_i(rp), .rx_byte_i(rb), .rx_tag_i(rt), .rx_flag_i(rf), .rx_abort_i(ra), .rx_enable_o(ren),
      .rx_short_addr_o(rsh), .int_bit2_evt_o(evt));
   hdfc_line_model i_line (.clk_i(clk_i), .tx_valid_i(tv), .tx_byte_i(tb), .tx_end_i(te), .tx_abandon_i(ta),
      .tx_fcs_i(tf), .tx_underrun_i(tu), .tx_pull_o(tp), .rx_push_o(rp), .rx_byte_o(rb), .rx_tag_o(rt),
      .rx_flag_o(rf), .rx_abort_o(ra));

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Ceiling well above the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic chk_bit(input logic e, input logic g);
      chk_byte({7'h00, e}, {7'h00, g});
   endtask

   task automatic chk_word(input logic [11:0] e, input logic [11:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] dd);
      @(posedge clk_i);
      cs <= 1'b1;
      wr <= 1'b1;
      addr <= a;
      wdata <= dd;
      @(posedge clk_i);
      cs <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [7:0] dd);
      @(posedge clk_i);
      cs <= 1'b1;
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_i);
      cs <= 1'b0;
      rd <= 1'b0;
      #1;
      dd = rdata;
   endtask

   function automatic logic [7:0] exp_status(input int unsigned tn, input int unsigned rn, input logic [1:0] tg);
      logic [1:0] t;
      logic [1:0] x;
      t = (tn == 0) ? 2'h2 : (tn >= LV_ST) ? 2'h0 : (tn >= LV_IN) ? 2'h1 : 2'h3;
      x = (rn == 0) ? 2'h0 : (rn >= LV_ST) ? 2'h2 : (rn >= LV_IN) ? 2'h3 : 2'h1;
      return {2'h0, (rn == 0) ? 2'h0 : tg, t, x};
   endfunction

   task automatic chk_stat();
      logic [7:0] s;
      bus_rd(`HDFC_ADDR_STATUS, s);
      chk_byte(exp_status(txq.size(), rxq.size(), (rxq.size() > 0) ? rxq[0][9:8] : 2'h0), s);
   endtask

   task automatic tx_put(input logic [7:0] b, input logic [7:0] tags);
      if (tags != 8'h00) bus_wr(`HDFC_ADDR_CTRL_FIRST, tags);
      bus_wr(`HDFC_ADDR_TX_FIFO, b);
      if (txq.size() < DEPTH) txq.push_back({tags[3], tags[4], b});
   endtask

   task automatic tx_take(input logic [9:0] e);
      i_line.pull($urandom_range(2), r);
      chk_word({2'h2, e}, r);
      chk_bit(e[8] && !crci, tf);
   endtask

   task automatic rx_put(input logic [1:0] t, input logic q);
      d = 8'($urandom());
      i_line.push(d, t);
      if (q && rxq.size() < DEPTH) rxq.push_back({t, d});
   endtask

   initial begin
      void'($urandom(32'h34f3_31fb));
      crci = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_i);
      bus_rd(A_C2, v);
      chk_byte(8'h00, v);
      chk_stat();
      bus_rd(8'h20, v);
      chk_byte(8'h00, v);
      repeat (4) begin
         d = 8'($urandom()) & 8'hf0;
         bus_wr(A_C2, d);
         bus_rd(A_C2, v);
         chk_byte(d, v);
         chk_bit(d[`HDFC_C2_CYCLE], tcyc);
         chk_bit(d[`HDFC_C2_SHORT_ADDR], rsh);
      end
      bus_wr(A_C2, 8'h80);
      for (int i = 0; i <= DEPTH; i++) begin
         chk_stat();
         tx_put(8'($urandom()), (i == 3) ? 8'h10 : (i == 5) ? 8'h08 : 8'h00);
      end
      chk_stat();
      chk_stat();
      while (txq.size() > 0) begin
         if (txq.size() == 5) begin
            bus_wr(A_C2, 8'ha0);
            crci = 1'b1;
         end
         tx_take(txq.pop_front());
      end
      i_line.pull(0, r);
      chk_byte(8'h40, {r[11:10], 6'h00});
      chk_bit(1'b1, evt);
      repeat (3) tx_put(8'($urandom()), 8'h00);
      bus_wr(A_C2, 8'h81);
      txq.delete();
      chk_stat();
      bus_rd(A_C2, v);
      chk_byte(8'h81, v);
      tx_put(8'h5a, 8'h10);
      bus_rd(A_C2, v);
      chk_byte(8'h80, v);
      chk_stat();
      bus_wr(A_C2, 8'h00);
      crci = 1'b0;
      tx_take(txq.pop_front());
      for (int i = 0; i <= DEPTH; i++) begin
         chk_stat();
         rx_put((i < 4) ? 2'(i) : 2'($urandom()), 1'b1);
      end
      while (rxq.size() > 0) begin
         chk_stat();
         bus_rd(`HDFC_ADDR_RX_FIFO, v);
         chk_byte(rxq[0][7:0], v);
         void'(rxq.pop_front());
      end
      bus_rd(`HDFC_ADDR_RX_FIFO, v);
      chk_byte(8'h00, v);
      repeat (2) rx_put(2'h1, 1'b1);
      bus_wr(A_C2, 8'h02);
      rxq.delete();
      chk_stat();
      rx_put(2'h1, 1'b0);
      chk_stat();
      i_line.pulse(1'b0);
      rx_put(2'h1, 1'b1);
      chk_stat();
      bus_wr(A_C2, 8'h00);
      i_line.pulse(1'b1);
      #1;
      chk_bit(1'b1, evt);
      repeat (2) @(posedge clk_i);
      give_verdict();
   end
endmodule // hdlc_fifo_status_and_control_tb
